/* urs_pkg.sv */
// Operation
// - With address matching on and nine-bit characters selected, characters whose ninth bit is one are detected as address characters, and the option does nothing in eight-bit mode.
// - A read-only receiver idle flag reads one while the receiver is idle and zero while a character is being received.
// - A read-only parity fault flag shows whether the character at the head of the receive queue had a parity error.
// - A read-only framing fault flag shows whether the character at the head of the receive queue had a framing error.
// - The overrun fault flag is set by the hardware when the receive queue overflows, reads zero otherwise, and software may only clear it.
// - Clearing a set overrun fault flag empties the receive queue and the receive shift register.
// - A read-only character-available flag reads one while the receive queue holds at least one unread character.
package urs_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] URS_STATUS_CONTROL_OFS = 8'h00;
  localparam logic [7:0] URS_LINE_CONFIG_OFS = 8'h04;
  localparam logic [7:0] URS_BAUD_DIVISOR_OFS = 8'h08;
  localparam logic [7:0] URS_RX_DATA_OFS = 8'h0c;
  localparam logic [7:0] URS_INT_STATUS_OFS = 8'h10;
  localparam logic [7:0] URS_INT_MASK_OFS = 8'h14;

  // Field positions of the status and control register.
  localparam int URS_ADDRESS_MATCH_ENABLE_BIT = 5;
  localparam int URS_RECEIVER_IDLE_FLAG_BIT = 4;
  localparam int URS_PARITY_FAULT_FLAG_BIT = 3;
  localparam int URS_FRAMING_FAULT_FLAG_BIT = 2;
  localparam int URS_OVERRUN_FAULT_FLAG_BIT = 1;
  localparam int URS_RX_CHAR_AVAILABLE_BIT = 0;

  // Field positions of the line configuration register.
  localparam int URS_NINE_BIT_MODE_BIT = 0;
  localparam int URS_PARITY_ENABLE_BIT = 1;
  localparam int URS_PARITY_ODD_BIT = 2;

  // Event positions shared by the interrupt status and mask registers.
  localparam int URS_EV_CHAR_BIT = 0;
  localparam int URS_EV_OVERRUN_BIT = 1;
  localparam int URS_EV_ADDRESS_BIT = 2;
  localparam int URS_EV_WIDTH = 3;

  // Reset values.
  localparam logic [15:0] URS_BAUD_DIVISOR_RST = 16'h01b2;
  localparam logic [2:0] URS_LINE_CONFIG_RST = 3'h0;
  localparam logic [2:0] URS_INT_MASK_RST = 3'h0;

  // Receive queue geometry and entry layout.
  localparam int URS_QUEUE_DEPTH = 4;
  localparam int URS_PTR_WIDTH = 2;
  localparam int URS_DATA_WIDTH = 9;
  localparam int URS_ENTRY_PAR_FAULT = 9;
  localparam int URS_ENTRY_FRAME_FAULT = 10;
  localparam int URS_ENTRY_WIDTH = 11;

  // AXI response codes.
  localparam logic [1:0] URS_RESP_OKAY = 2'h0;
  localparam logic [1:0] URS_RESP_SLVERR = 2'h2;

  // Receiver sequencing states.
  typedef enum logic [2:0] {
    URS_ST_IDLE,
    URS_ST_START,
    URS_ST_DATA,
    URS_ST_PARITY,
    URS_ST_STOP
  } urs_state_t;

endpackage

/* urs_receive_status.sv */
`timescale 1ns/100ps
module urs_receive_status (
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic receiver_idle
);
  import urs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r, idle_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_got_nxt, w_got_nxt, bvalid_nxt;
  logic do_write, do_read, wr_hit;
  logic address_match_enable_r;
  logic [2:0] line_cfg_r;
  logic [15:0] baud_r;
  logic [URS_EV_WIDTH-1:0] ist_r, mask_r, events;
  logic overrun_fault_flag_r;
  urs_state_t state_r;
  logic [15:0] cnt_r;
  logic [3:0] bit_idx_r;
  logic [URS_DATA_WIDTH-1:0] shreg_r;
  logic pbit_r;
  logic [URS_ENTRY_WIDTH-1:0] queue_mem [URS_QUEUE_DEPTH];
  logic [URS_PTR_WIDTH-1:0] wr_ptr_r, rd_ptr_r;
  logic [URS_PTR_WIDTH:0] count_r;
  logic nine_bit, par_en, par_odd, q_full, q_empty;
  logic char_done, accept, push, pop, overrun_set, flush;
  logic [URS_DATA_WIDTH-1:0] rx_char;
  logic par_fault_new, frame_fault_new;
  logic [URS_ENTRY_WIDTH-1:0] head;
  logic [31:0] status_word, rd_word;
  logic rd_hit;

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq = irq_r;
  assign receiver_idle = idle_r;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are held until both are present.
  always_comb begin
    do_write = aw_got_r & w_got_r & ~bvalid_r;
    aw_got_nxt = (aw_got_r | (s_axi_awvalid & awready_r)) & ~do_write;
    w_got_nxt = (w_got_r | (s_axi_wvalid & wready_r)) & ~do_write;
    bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);
    wr_hit = (awaddr_r == URS_STATUS_CONTROL_OFS) | (awaddr_r == URS_LINE_CONFIG_OFS) |
             (awaddr_r == URS_BAUD_DIVISOR_OFS) | (awaddr_r == URS_INT_MASK_OFS);
  end

  // Handshake flops of the write side; ready stays low while a write is pending.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bresp_r <= URS_RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      bvalid_r <= bvalid_nxt;
      awready_r <= ~aw_got_nxt & ~bvalid_nxt;
      wready_r <= ~w_got_nxt & ~bvalid_nxt;
      if (s_axi_awvalid && awready_r) begin
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_r <= wr_hit ? URS_RESP_OKAY : URS_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written configuration registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      address_match_enable_r <= 1'b0;
      line_cfg_r <= URS_LINE_CONFIG_RST;
      baud_r <= URS_BAUD_DIVISOR_RST;
      mask_r <= URS_INT_MASK_RST;
    end else if (do_write && wstrb_r[0]) begin
      case (awaddr_r)
        URS_STATUS_CONTROL_OFS: begin
          address_match_enable_r <= wdata_r[URS_ADDRESS_MATCH_ENABLE_BIT];
        end
        URS_LINE_CONFIG_OFS: begin
          line_cfg_r <= wdata_r[2:0];
        end
        URS_BAUD_DIVISOR_OFS: begin
          baud_r[7:0] <= wdata_r[7:0];
          if (wstrb_r[1]) begin
            baud_r[15:8] <= wdata_r[15:8];
          end
        end
        URS_INT_MASK_OFS: begin
          mask_r <= wdata_r[URS_EV_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // A zero written over a set overrun flag flushes the receive path.
  assign flush = do_write & wstrb_r[0] & (awaddr_r == URS_STATUS_CONTROL_OFS) &
                 ~wdata_r[URS_OVERRUN_FAULT_FLAG_BIT] & overrun_fault_flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: side effects occur when the address is taken.
  assign do_read = s_axi_arvalid & arready_r;
  assign pop = do_read & (s_axi_araddr[7:2] == URS_RX_DATA_OFS[7:2]) & ~q_empty;
  assign head = queue_mem[rd_ptr_r];

  // Status word built from the live receiver and queue state.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[URS_ADDRESS_MATCH_ENABLE_BIT] = address_match_enable_r;
    status_word[URS_RECEIVER_IDLE_FLAG_BIT] = idle_r;
    status_word[URS_PARITY_FAULT_FLAG_BIT] = ~q_empty & head[URS_ENTRY_PAR_FAULT];
    status_word[URS_FRAMING_FAULT_FLAG_BIT] = ~q_empty & head[URS_ENTRY_FRAME_FAULT];
    status_word[URS_OVERRUN_FAULT_FLAG_BIT] = overrun_fault_flag_r;
    status_word[URS_RX_CHAR_AVAILABLE_BIT] = ~q_empty;
  end

  // Read data multiplexer; unmapped offsets read zero with an error response.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      URS_STATUS_CONTROL_OFS: rd_word = status_word;
      URS_LINE_CONFIG_OFS: rd_word = {29'h0, line_cfg_r};
      URS_BAUD_DIVISOR_OFS: rd_word = {16'h0000, baud_r};
      URS_RX_DATA_OFS: rd_word = q_empty ? 32'h0000_0000 : {23'h0, head[URS_DATA_WIDTH-1:0]};
      URS_INT_STATUS_OFS: rd_word = {29'h0, ist_r};
      URS_INT_MASK_OFS: rd_word = {29'h0, mask_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read handshake; one read is served at a time.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= URS_RESP_OKAY;
    end else begin
      if (do_read) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? URS_RESP_OKAY : URS_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end else if (!rvalid_r) begin
        arready_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial receiver: start bit, data bits, optional parity and one stop bit.
  assign nine_bit = line_cfg_r[URS_NINE_BIT_MODE_BIT];
  assign par_en = line_cfg_r[URS_PARITY_ENABLE_BIT];
  assign par_odd = line_cfg_r[URS_PARITY_ODD_BIT];
  assign char_done = (state_r == URS_ST_STOP) & (cnt_r == 16'h0000);
  assign rx_char = nine_bit ? shreg_r : {1'b0, shreg_r[8:1]};
  assign par_fault_new = par_en & ((^rx_char ^ pbit_r) != par_odd);
  assign frame_fault_new = ~rx_in;

  // Bits are sampled in mid-cell; a flush drops the character in progress.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= URS_ST_IDLE;
      cnt_r <= 16'h0000;
      bit_idx_r <= 4'h0;
      shreg_r <= '0;
      pbit_r <= 1'b0;
    end else if (flush) begin
      state_r <= URS_ST_IDLE;
      shreg_r <= '0;
      bit_idx_r <= 4'h0;
      cnt_r <= 16'h0000;
    end else begin
      case (state_r)
        URS_ST_IDLE: begin
          if (!rx_in) begin
            state_r <= URS_ST_START;
            cnt_r <= {1'b0, baud_r[15:1]};
          end
        end
        URS_ST_START: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else if (!rx_in) begin
            state_r <= URS_ST_DATA;
            cnt_r <= baud_r - 16'h0001;
            bit_idx_r <= 4'h0;
          end else begin
            state_r <= URS_ST_IDLE;
          end
        end
        URS_ST_DATA: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            shreg_r <= {rx_in, shreg_r[8:1]};
            cnt_r <= baud_r - 16'h0001;
            bit_idx_r <= bit_idx_r + 4'h1;
            if (bit_idx_r == (nine_bit ? 4'h8 : 4'h7)) begin
              state_r <= par_en ? URS_ST_PARITY : URS_ST_STOP;
            end
          end
        end
        URS_ST_PARITY: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            pbit_r <= rx_in;
            cnt_r <= baud_r - 16'h0001;
            state_r <= URS_ST_STOP;
          end
        end
        URS_ST_STOP: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            state_r <= URS_ST_IDLE;
          end
        end
        default: state_r <= URS_ST_IDLE;
      endcase
    end
  end

  // Idle flag changes on the same edge as the sequencer at a start bit and at the mid-cell sample of the stop bit.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_r <= 1'b1;
    end else begin
      idle_r <= (state_r == URS_ST_IDLE) ? (rx_in | flush) : char_done | flush;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive queue with per-character error bits.
  assign accept = ~(nine_bit & address_match_enable_r & ~rx_char[8]);
  assign q_full = (count_r == (URS_PTR_WIDTH + 1)'(URS_QUEUE_DEPTH));
  assign q_empty = (count_r == '0);
  assign push = char_done & accept & ~overrun_fault_flag_r & ~q_full & ~flush;
  assign overrun_set = char_done & accept & ~overrun_fault_flag_r & q_full & ~flush;

  // Entry storage is written only on push.
  always_ff @(posedge clk) begin
    if (push) begin
      queue_mem[wr_ptr_r] <= {frame_fault_new, par_fault_new, rx_char};
    end
  end

  // Pointer and count update; flush empties the queue.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (URS_PTR_WIDTH + 1)'(push) - (URS_PTR_WIDTH + 1)'(pop);
    end
  end

  // Overrun flag: set only by hardware, cleared only by a software zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overrun_fault_flag_r <= 1'b0;
    end else if (overrun_set) begin
      overrun_fault_flag_r <= 1'b1;
    end else if (flush) begin
      overrun_fault_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky events, cleared by a read, a new event wins.
  assign events[URS_EV_CHAR_BIT] = push;
  assign events[URS_EV_OVERRUN_BIT] = overrun_set;
  assign events[URS_EV_ADDRESS_BIT] = push & nine_bit & address_match_enable_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ist_r <= '0;
    end else if (do_read && (s_axi_araddr[7:2] == URS_INT_STATUS_OFS[7:2])) begin
      ist_r <= events;
    end else begin
      ist_r <= ist_r | events;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(ist_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_addr_char_only: assert property (char_done && nine_bit && address_match_enable_r &&
    !rx_char[8] && !pop && !flush |=> count_r == $past(count_r))
    else $error("Data character entered queue in address mode.");
  a_idle_on_start: assert property (state_r == URS_ST_IDLE && !rx_in && !flush ##1 !flush
    |-> !idle_r ##1 !status_word[URS_RECEIVER_IDLE_FLAG_BIT])
    else $error("Idle flag did not drop at start bit.");
  a_parity_head_flag: assert property (push && q_empty && par_fault_new && !pop
    |=> status_word[URS_PARITY_FAULT_FLAG_BIT])
    else $error("Parity flag missing for head character.");
  a_framing_head_flag: assert property (push && q_empty && !frame_fault_new && !pop
    |=> !status_word[URS_FRAMING_FAULT_FLAG_BIT])
    else $error("Framing flag set for clean head character.");
  a_overrun_set_hold: assert property (overrun_set |=> overrun_fault_flag_r [*2]
    or (overrun_fault_flag_r ##1 $fell(overrun_fault_flag_r)))
    else $error("Overrun flag not set on overflow.");
  a_overrun_no_set: assert property (!overrun_fault_flag_r && !overrun_set
    |=> !overrun_fault_flag_r)
    else $error("Overrun flag set without overflow.");
  a_flush_empties: assert property (flush |=> q_empty && state_r == URS_ST_IDLE &&
    !overrun_fault_flag_r && shreg_r == '0)
    else $error("Clearing overrun did not empty receive path.");
  a_avail_after_push: assert property (push && q_empty |=>
    status_word[URS_RX_CHAR_AVAILABLE_BIT])
    else $error("Available flag missing after first character.");
  a_discard_on_overrun: assert property (overrun_fault_flag_r && char_done && !pop && !flush
    |=> count_r == $past(count_r))
    else $error("Character stored while overrun flag set.");

  c_char_stored: cover property (push ##[1:1000] pop);
  c_overrun_flush: cover property (overrun_set ##[1:1000] flush);
  c_addr_char: cover property (events[URS_EV_ADDRESS_BIT]);
  c_irq_raised: cover property ($rose(irq_r));

endmodule

/* urs_serial_tx.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Remote transmitter that puts asynchronous characters on the receive line.
module urs_serial_tx #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk,
  output logic line
);
  ////////////////////////////////////////////////////////////////////////////////
  // The line rests high between characters, like a released line with a pull-up.
  initial begin
    line = 1'b1;
  end

  // Drives one level for a number of clock cycles, changing just after an edge.
  task automatic hold_bit(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clk);
  endtask

  // Sends start, data bits from the lowest, optional parity and the stop bit.
  // A broken stop bit is pulled low only long enough to be sampled, so the
  // receiver sees a false start afterwards and drops back to idle.
  task automatic send(input logic [8:0] d, input bit nine, input bit par, input bit odd,
                      input bit bad_par, input bit bad_stop);
    int i;
    logic p;
    p = (nine ? ^d : ^d[7:0]) ^ odd ^ bad_par;
    @(posedge clk);
    hold_bit(1'b0, BIT_CYCLES);
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      hold_bit(d[i], BIT_CYCLES);
    end
    if (par) begin
      hold_bit(p, BIT_CYCLES);
    end
    if (bad_stop) begin
      hold_bit(1'b0, BIT_CYCLES * 13 / 16);
    end
    hold_bit(1'b1, BIT_CYCLES);
  endtask
endmodule

/* tb_uart_receive_status.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
`define chk_eq(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_uart_receive_status;
  import urs_pkg::*;
  localparam int BITC = 16;
  logic clk, reset, rx_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, receiver_idle;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int checks_done = 0;

  // Clock and initial values of reset and the bus inputs; rx_in is set by the transmitter.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
  end

  urs_receive_status dut (.clk(clk), .reset(reset), .rx_in(rx_in), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .receiver_idle(receiver_idle));
  urs_serial_tx #(.BIT_CYCLES(BITC)) tx (.clk(clk), .line(rx_in));

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One bus write; address and data are released each at its own handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 1000; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        `chk_eq("write response", er, bresp)
        break;
      end
    end
    if (n == 1000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  // One bus read; data and response are taken at the edge that shows rvalid.
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 1000; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        rready <= 1'b0;
        `chk_eq("read response", er, rresp)
        break;
      end
    end
    if (n == 1000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  // Reads a mapped register and compares it.
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] v;
    rd(a, URS_RESP_OKAY, v);
    `chk_eq(nm, ex, v)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped accesses, then a short bit time.
  task automatic sc_reset();
    logic [31:0] v;
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h10, "status at reset");
    `chk_eq("idle pin", 1'b1, receiver_idle)
    chk_rd(URS_LINE_CONFIG_OFS, 32'h0, "config at reset");
    chk_rd(URS_INT_MASK_OFS, 32'h0, "mask at reset");
    chk_rd(URS_BAUD_DIVISOR_OFS, {16'h0, URS_BAUD_DIVISOR_RST}, "baud at reset");
    rd(8'h1c, URS_RESP_SLVERR, v);
    `chk_eq("unmapped read", 32'h0, v)
    wr(8'h1c, 32'hffff_ffff, URS_RESP_SLVERR);
    wr(URS_BAUD_DIVISOR_OFS, BITC, URS_RESP_OKAY);
  endtask

  // A plain character: busy while it arrives, available once queued.
  task automatic sc_basic();
    fork
      tx.send(9'h05a, 0, 0, 0, 0, 0);
      begin
        repeat (3 * BITC) @(posedge clk);
        `chk_eq("idle pin busy", 1'b0, receiver_idle)
        chk_rd(URS_STATUS_CONTROL_OFS, 32'h00, "status busy");
      end
    join
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h11, "status one char");
    chk_rd(URS_RX_DATA_OFS, 32'h05a, "data plain");
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h10, "status drained");
    `chk_eq("masked irq", 1'b0, irq)
  endtask

  // Error flags follow the head of the queue, not the newest character.
  task automatic sc_errors();
    wr(URS_LINE_CONFIG_OFS, 32'h2, URS_RESP_OKAY);
    tx.send(9'h05a, 0, 1, 0, 1, 0);
    tx.send(9'h03c, 0, 1, 0, 0, 1);
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h19, "status parity head");
    chk_rd(URS_RX_DATA_OFS, 32'h05a, "data parity char");
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h15, "status framing head");
    chk_rd(URS_RX_DATA_OFS, 32'h03c, "data framing char");
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h10, "status after errors");
    wr(URS_LINE_CONFIG_OFS, 32'h6, URS_RESP_OKAY);
    tx.send(9'h001, 0, 1, 1, 0, 0);
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h11, "status odd parity");
    chk_rd(URS_RX_DATA_OFS, 32'h001, "data odd parity");
  endtask

  // Address matching keeps only ninth-bit characters, and only in nine-bit mode.
  task automatic sc_address();
    wr(URS_LINE_CONFIG_OFS, 32'h1, URS_RESP_OKAY);
    wr(URS_STATUS_CONTROL_OFS, 32'h20, URS_RESP_OKAY);
    tx.send(9'h055, 1, 0, 0, 0, 0);
    tx.send(9'h1a5, 1, 0, 0, 0, 0);
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h31, "status address mode");
    chk_rd(URS_RX_DATA_OFS, 32'h1a5, "data address char");
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h30, "status data dropped");
    chk_rd(URS_INT_STATUS_OFS, 32'h5, "event address char");
    wr(URS_LINE_CONFIG_OFS, 32'h0, URS_RESP_OKAY);
    tx.send(9'h033, 0, 0, 0, 0, 0);
    chk_rd(URS_RX_DATA_OFS, 32'h033, "data eight-bit");
    wr(URS_STATUS_CONTROL_OFS, 32'h00, URS_RESP_OKAY);
  endtask

  // Overflow, flush on clear, and dropping while the fault stands.
  task automatic sc_overrun();
    int i;
    wr(URS_STATUS_CONTROL_OFS, 32'h02, URS_RESP_OKAY);
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h10, "overrun not settable");
    for (i = 0; i < URS_QUEUE_DEPTH + 1; i++) tx.send(9'(8'h10 + i), 0, 0, 0, 0, 0);
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h13, "status overflowed");
    chk_rd(URS_INT_STATUS_OFS, 32'h3, "event overrun");
    wr(URS_STATUS_CONTROL_OFS, 32'h00, URS_RESP_OKAY);
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h10, "status flushed");
    for (i = 0; i < URS_QUEUE_DEPTH + 1; i++) tx.send(9'(8'h10 + i), 0, 0, 0, 0, 0);
    chk_rd(URS_RX_DATA_OFS, 32'h10, "data first kept");
    tx.send(9'h099, 0, 0, 0, 0, 0);
    for (i = 1; i < URS_QUEUE_DEPTH; i++) chk_rd(URS_RX_DATA_OFS, 32'h10 + i, "data kept");
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h12, "status late char dropped");
    wr(URS_STATUS_CONTROL_OFS, 32'h00, URS_RESP_OKAY);
    chk_rd(URS_STATUS_CONTROL_OFS, 32'h10, "status cleared");
  endtask

  // Interrupt raised only when unmasked, and dropped by reading the events.
  task automatic sc_irq();
    logic [31:0] v;
    rd(URS_INT_STATUS_OFS, URS_RESP_OKAY, v);
    tx.send(9'h042, 0, 0, 0, 0, 0);
    repeat (3) @(posedge clk);
    `chk_eq("irq masked", 1'b0, irq)
    wr(URS_INT_MASK_OFS, 32'h1, URS_RESP_OKAY);
    repeat (3) @(posedge clk);
    `chk_eq("irq unmasked", 1'b1, irq)
    chk_rd(URS_INT_STATUS_OFS, 32'h1, "event status");
    repeat (3) @(posedge clk);
    `chk_eq("irq after clear", 1'b0, irq)
    chk_rd(URS_INT_STATUS_OFS, 32'h0, "event status cleared");
    chk_rd(URS_RX_DATA_OFS, 32'h042, "data irq char");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    sc_reset();
    sc_basic();
    sc_errors();
    sc_address();
    sc_overrun();
    sc_irq();
    end_of_test();
  end
endmodule
